// ---- rtl/buck_ctrl_pkg.sv ----
// constants shared by the regulator control block
// assumes a 250 MHz system clock and the serial control pins of the device
package buck_ctrl_pkg;
    // ------------------------------------------------------------
    // serial slave address and register offsets
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam logic [7:0] OFS_OUTPUT_VOLTAGE_SELECT = 8'h00;
    localparam logic [7:0] OFS_SYSTEM_CONTROL_ONE = 8'h01;
    localparam logic [7:0] OFS_SYSTEM_CONTROL_TWO = 8'h02;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SW_ENABLE_BIT = 7;
    localparam int FSW_LSB = 5;
    localparam int PG_WINDOW_BIT = 2;
    localparam int OVP_ENABLE_BIT = 1;
    localparam int CCM_BIT = 0;
    localparam int PERMIT_BIT = 5;
    localparam int DISCHARGE_BIT = 4;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // code 78 -> 0.6 V + 78 * 3.9 mV, nearest step to 0.9031 V
    localparam logic [6:0] DEFAULT_REF_CODE = 7'h4e;
    localparam logic [7:0] RST_OUTPUT_VOLTAGE_SELECT = 8'hce;
    // fsw code 3'h2 (1.67 MHz), window both sides, ovp on, forced ccm
    localparam logic [7:0] RST_SYSTEM_CONTROL_ONE = 8'h47;
    // permit off, discharge off, slew 3'h6 (1 mV/us)
    localparam logic [7:0] RST_SYSTEM_CONTROL_TWO = 8'h06;
    // ------------------------------------------------------------
    // timing: one 3.9 mV step at 64 mV/us, doubled per slew code
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STEP_TIME_64_PS = 60937;
    localparam int STEP_CYCLES_64 = STEP_TIME_64_PS / CLK_PERIOD_PS;
    // ------------------------------------------------------------
    // serial engine states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_RACK = 3'b101
    } link_state_e;
endpackage

// ---- rtl/buck_regulator_i2c_control.sv ----
// serial control logic of a step-down regulator: slave, registers, enable,
// reference ramp, input over-voltage latch and power-good output
// assumes analog comparators drive the status inputs asynchronously
//
// How it works
// - slave answers at 7-bit address 0x68 (0xd0 write, 0xd1 read).
// - bit 7 of output select register is the software converter enable.
// - converter runs only when enable pin and software enable are both high.
// - reset target is the 0.9031 V code; 3.9 mV steps from 0.6 V.
// - bits 6:0 of output select register hold the reference code.
// - control one bits 7:5 pick switching frequency, reset to 1.67 MHz.
// - window bit resets 1 (both sides); 0 flags only low excursions.
// - ovp bit resets 1; input above 6.3 V stops, below 6.05 V restarts.
// - with ovp bit cleared the converter ignores input over-voltage.
// - control one bit 0 resets 1 forced continuous; 0 is pulse skipping.
// - discharge bit resets 0; 1 enables the internal pull-down.
// - control two bits 2:0 pick one of eight reference slew rates.
// - reference ramps one step per slew period toward a new target.
// - two-sided power-good is high only inside the 85 to 115 % window.
`timescale 1ns/100ps
module buck_regulator_i2c_control (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // serial bus pins
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    // pins and analog comparators
    input wire logic EN_PIN,
    input wire logic VIN_ABOVE_TRIP,
    input wire logic VIN_BELOW_RECOVER,
    input wire logic VOUT_ABOVE_WINDOW,
    input wire logic VOUT_BELOW_WINDOW,
    // converter core controls
    output logic CONVERTER_ON,
    output logic FORCED_CONTINUOUS_MODE,
    output logic [2:0] SWITCH_FREQ_CODE,
    output logic DISCHARGE_ENABLE,
    output logic [6:0] REFERENCE_CODE,
    // open-drain power-good pin
    output logic OUTPUT_IN_REGULATION_OUT,
    output logic OUTPUT_IN_REGULATION_OE
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // bit map: 0 scl, 1 sda, 2 enable pin, 3 vin trip, 4 vin recover,
    // 5 vout above window, 6 vout below window
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic scl_prev;
    logic sda_prev;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_a <= 7'h03;
            sync_b <= 7'h03;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            sync_a <= {VOUT_BELOW_WINDOW, VOUT_ABOVE_WINDOW, VIN_BELOW_RECOVER,
                       VIN_ABOVE_TRIP, EN_PIN, SDA_IN, SCL};
            sync_b <= sync_a;
            scl_prev <= sync_b[0];
            sda_prev <= sync_b[1];
        end
    end
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl = sync_b[0];
    assign sda = sync_b[1];
    assign scl_rise = scl & ~scl_prev;
    assign scl_fall = ~scl & scl_prev;
    assign start_cond = scl & scl_prev & sda_prev & ~sda;
    assign stop_cond = scl & scl_prev & ~sda_prev & sda;

    function automatic logic [11:0] step_cycles(input logic [2:0] code);
        step_cycles = 12'(buck_ctrl_pkg::STEP_CYCLES_64) << code;
    endfunction

    // ------------------------------------------------------------
    // serial slave and register file
    // ------------------------------------------------------------
    buck_ctrl_pkg::link_state_e state;
    buck_ctrl_pkg::link_state_e next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic rw;
    logic next_rw;
    logic first;
    logic next_first;
    logic sda_oe;
    logic next_sda_oe;
    logic [7:0] output_voltage_select;
    logic [7:0] next_output_voltage_select;
    logic [7:0] ctl1;
    logic [7:0] next_ctl1;
    logic [7:0] ctl2;
    logic [7:0] next_ctl2;
    logic [7:0] rdata;

    always_comb begin
        unique case (ptr)
            buck_ctrl_pkg::OFS_OUTPUT_VOLTAGE_SELECT: rdata = output_voltage_select;
            buck_ctrl_pkg::OFS_SYSTEM_CONTROL_ONE: rdata = ctl1;
            buck_ctrl_pkg::OFS_SYSTEM_CONTROL_TWO: rdata = ctl2;
            default: rdata = 8'h00;
        endcase
    end

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_rw = rw;
        next_first = first;
        next_sda_oe = sda_oe;
        next_output_voltage_select = output_voltage_select;
        next_ctl1 = ctl1;
        next_ctl2 = ctl2;
        if (start_cond) begin
            next_state = buck_ctrl_pkg::ST_ADDR;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else if (stop_cond) begin
            next_state = buck_ctrl_pkg::ST_IDLE;
            next_sda_oe = 1'b0;
        end else begin
            unique case (state)
                buck_ctrl_pkg::ST_IDLE: begin
                end
                buck_ctrl_pkg::ST_ADDR, buck_ctrl_pkg::ST_WDATA: begin
                    if (scl_rise && cnt != 4'h8) begin
                        next_shreg = {shreg[6:0], sda};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == 4'h8) begin
                        next_cnt = 4'h0;
                        next_state = buck_ctrl_pkg::ST_ACK;
                        next_sda_oe = 1'b1;
                        if (state == buck_ctrl_pkg::ST_ADDR) begin
                            next_rw = shreg[0];
                            next_first = 1'b1;
                            if (shreg[7:1] != buck_ctrl_pkg::SLAVE_ADDR) begin
                                next_state = buck_ctrl_pkg::ST_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end else if (first) begin
                            next_ptr = shreg;
                            next_first = 1'b0;
                        end else begin
                            unique case (ptr)
                                buck_ctrl_pkg::OFS_OUTPUT_VOLTAGE_SELECT: next_output_voltage_select = shreg;
                                buck_ctrl_pkg::OFS_SYSTEM_CONTROL_ONE: next_ctl1 = shreg;
                                buck_ctrl_pkg::OFS_SYSTEM_CONTROL_TWO:
                                    next_ctl2 = shreg & 8'hf7;
                                default: begin
                                end
                            endcase
                            next_ptr = ptr + 8'h01;
                        end
                    end
                end
                buck_ctrl_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            next_shreg = {rdata[6:0], 1'b0};
                            next_sda_oe = ~rdata[7];
                            next_cnt = 4'h1;
                            next_ptr = ptr + 8'h01;
                            next_state = buck_ctrl_pkg::ST_RDATA;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state = buck_ctrl_pkg::ST_WDATA;
                        end
                    end
                end
                buck_ctrl_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt == 4'h8) begin
                            next_sda_oe = 1'b0;
                            next_state = buck_ctrl_pkg::ST_RACK;
                        end else begin
                            next_sda_oe = ~shreg[7];
                            next_shreg = {shreg[6:0], 1'b0};
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                buck_ctrl_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        next_state = sda ? buck_ctrl_pkg::ST_IDLE : buck_ctrl_pkg::ST_ACK;
                    end
                end
                default: next_state = buck_ctrl_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= buck_ctrl_pkg::ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 8'h00;
            rw <= 1'b0;
            first <= 1'b0;
            sda_oe <= 1'b0;
            output_voltage_select <= buck_ctrl_pkg::RST_OUTPUT_VOLTAGE_SELECT;
            ctl1 <= buck_ctrl_pkg::RST_SYSTEM_CONTROL_ONE;
            ctl2 <= buck_ctrl_pkg::RST_SYSTEM_CONTROL_TWO;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            rw <= next_rw;
            first <= next_first;
            sda_oe <= next_sda_oe;
            output_voltage_select <= next_output_voltage_select;
            ctl1 <= next_ctl1;
            ctl2 <= next_ctl2;
        end
    end

    // ------------------------------------------------------------
    // converter control, reference ramp and power-good
    // ------------------------------------------------------------
    logic ovp_trip;
    logic next_ovp_trip;
    logic [11:0] ramp_cnt;
    logic [11:0] next_ramp_cnt;
    logic [6:0] ref_code;
    logic [6:0] next_ref_code;
    logic [6:0] target;
    logic conv_on;
    logic next_conv_on;
    logic pg_good;
    logic next_pg_good;

    always_comb begin
        // the default code stays until the permit bit is set
        target = ctl2[buck_ctrl_pkg::PERMIT_BIT] ? output_voltage_select[6:0]
                                                 : buck_ctrl_pkg::DEFAULT_REF_CODE;
        next_ovp_trip = ovp_trip;
        if (!ctl1[buck_ctrl_pkg::OVP_ENABLE_BIT]) begin
            next_ovp_trip = 1'b0;
        end else if (sync_b[3]) begin
            next_ovp_trip = 1'b1;
        end else if (sync_b[4]) begin
            next_ovp_trip = 1'b0;
        end
        next_conv_on = sync_b[2] & output_voltage_select[buck_ctrl_pkg::SW_ENABLE_BIT] & ~ovp_trip;
        next_ref_code = ref_code;
        next_ramp_cnt = 12'h000;
        if (ref_code != target) begin
            next_ramp_cnt = ramp_cnt + 12'h001;
            if (ramp_cnt + 12'h001 >= step_cycles(ctl2[2:0])) begin
                next_ramp_cnt = 12'h000;
                next_ref_code = (target > ref_code) ? ref_code + 7'h01 : ref_code - 7'h01;
            end
        end
        if (ctl1[buck_ctrl_pkg::PG_WINDOW_BIT]) begin
            next_pg_good = conv_on & ~sync_b[6] & ~sync_b[5];
        end else begin
            next_pg_good = conv_on & ~sync_b[6];
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ovp_trip <= 1'b0;
            ramp_cnt <= 12'h000;
            ref_code <= buck_ctrl_pkg::DEFAULT_REF_CODE;
            conv_on <= 1'b0;
            pg_good <= 1'b0;
        end else begin
            ovp_trip <= next_ovp_trip;
            ramp_cnt <= next_ramp_cnt;
            ref_code <= next_ref_code;
            conv_on <= next_conv_on;
            pg_good <= next_pg_good;
        end
    end

    // ------------------------------------------------------------
    // outputs from flip-flops, OUTPUT_IN_REGULATION_OE through an inverter, except SDA_OUT and OUTPUT_IN_REGULATION_OUT which are tied low
    // ------------------------------------------------------------
    assign SDA_OUT = 1'b0;
    assign SDA_OE = sda_oe;
    assign CONVERTER_ON = conv_on;
    assign FORCED_CONTINUOUS_MODE = ctl1[buck_ctrl_pkg::CCM_BIT];
    assign SWITCH_FREQ_CODE = ctl1[7:buck_ctrl_pkg::FSW_LSB];
    assign DISCHARGE_ENABLE = ctl2[buck_ctrl_pkg::DISCHARGE_BIT];
    assign REFERENCE_CODE = ref_code;
    assign OUTPUT_IN_REGULATION_OUT = 1'b0;
    assign OUTPUT_IN_REGULATION_OE = ~pg_good;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    chk_addr_nack: assert property (
        (state == buck_ctrl_pkg::ST_ADDR && scl_fall && cnt == 4'h8 && !start_cond
         && !stop_cond && shreg[7:1] != buck_ctrl_pkg::SLAVE_ADDR) |=> !sda_oe)
        else $error("foreign address acknowledged");
    chk_addr_ack: assert property (
        (state == buck_ctrl_pkg::ST_ADDR && scl_fall && cnt == 4'h8 && !start_cond
         && !stop_cond && shreg[7:1] == buck_ctrl_pkg::SLAVE_ADDR) |=> sda_oe)
        else $error("own address not acknowledged");
    chk_swen_off: assert property (
        !output_voltage_select[buck_ctrl_pkg::SW_ENABLE_BIT] |=> !conv_on)
        else $error("converter on with software enable low");
    chk_pin_off: assert property (!sync_b[2] |=> !conv_on)
        else $error("converter on with enable pin low");
    chk_ovp_stop: assert property (
        ctl1[buck_ctrl_pkg::OVP_ENABLE_BIT] && sync_b[3] |=> ##1 !conv_on)
        else $error("converter kept running over input trip");
    chk_ovp_off: assert property (
        !ctl1[buck_ctrl_pkg::OVP_ENABLE_BIT] |=> !ovp_trip)
        else $error("trip latched while protection disabled");
    chk_ramp_step: assert property (
        ref_code != $past(ref_code) |-> (ref_code - $past(ref_code) == 7'h01)
        || ($past(ref_code) - ref_code == 7'h01))
        else $error("reference jumped more than one step");
    chk_ramp_hold: assert property (
        (ref_code != target && ramp_cnt == 12'h000 && $stable(target)
         && ctl2[2:0] == 3'h0) |=> ($stable(ref_code)) [*8])
        else $error("reference stepped before slew period");
    chk_pg_window: assert property (
        ctl1[buck_ctrl_pkg::PG_WINDOW_BIT] && sync_b[5] |=> OUTPUT_IN_REGULATION_OE)
        else $error("power-good high above window");
    chk_pg_low: assert property (
        sync_b[6] |=> OUTPUT_IN_REGULATION_OE)
        else $error("power-good high below window");

    cov_write: cover property (state == buck_ctrl_pkg::ST_WDATA && scl_fall && cnt == 4'h8);
    cov_read: cover property (state == buck_ctrl_pkg::ST_RACK && scl_rise);
    cov_ramp: cover property (ref_code != buck_ctrl_pkg::DEFAULT_REF_CODE);
    cov_ovp: cover property (ovp_trip ##1 !ovp_trip);
endmodule

// ---- sim/i2c_host_model.sv ----
// serial bus host model: drives the clock line and pulls the data line low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/100ps
module i2c_host_model (
    // system clock
    input wire logic clk,
    // serial bus
    output logic scl,
    output logic sda_low,
    input wire logic sda_wire
);
    localparam int QTR = 5;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ------------------------------------------------------------
    // bus phases, all moves just after a falling clock edge
    // ------------------------------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data set mid-low, sampled at end of high
    task automatic bit_io(input logic b, output logic r);
        wait_clk(QTR);
        sda_low = !b;
        wait_clk(QTR);
        scl = 1'b1;
        wait_clk(2 * QTR);
        r = sda_wire;
        scl = 1'b0;
    endtask
    task automatic start();
        wait_clk(QTR);
        sda_low = 1'b0;
        wait_clk(QTR);
        scl = 1'b1;
        wait_clk(2 * QTR);
        sda_low = 1'b1;
        wait_clk(2 * QTR);
        scl = 1'b0;
    endtask
    task automatic stop();
        wait_clk(QTR);
        sda_low = 1'b1;
        wait_clk(QTR);
        scl = 1'b1;
        wait_clk(2 * QTR);
        sda_low = 1'b0;
        wait_clk(2 * QTR);
    endtask
    // msb first; returns 1 when not acknowledged
    task automatic write_byte(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, nak);
    endtask
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the regulator control block
// assumes the host model owns the serial pins and data has a pull-up
`timescale 1ns/100ps
module tb_top;
    logic clk;
    logic sys_rst;
    logic scl;
    logic sda_low;
    logic sda_oe;
    wire logic sda_wire;
    logic en_pin;
    logic vin_above;
    logic vin_below;
    logic vout_above;
    logic vout_below;
    logic conv_on;
    logic fcm;
    logic [2:0] fsw;
    logic dis_en;
    logic [6:0] ref_code;
    logic pg_oe;
    logic sda_out;
    logic pg_out;
    logic [7:0] rd;
    logic ack;
    logic [6:0] cur;
    logic [6:0] tgt;
    logic [7:0] rst_tab [4] = '{8'hce, 8'h47, 8'h06, 8'h00};
    int n_mismatch;
    int n_compared;
    int n;
    assign sda_wire = !(sda_low | sda_oe);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    buck_regulator_i2c_control u_buck_regulator_i2c_control (
        .CLK(clk), .SYS_RST(sys_rst), .SCL(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .EN_PIN(en_pin), .VIN_ABOVE_TRIP(vin_above),
        .VIN_BELOW_RECOVER(vin_below), .VOUT_ABOVE_WINDOW(vout_above),
        .VOUT_BELOW_WINDOW(vout_below), .CONVERTER_ON(conv_on),
        .FORCED_CONTINUOUS_MODE(fcm), .SWITCH_FREQ_CODE(fsw), .DISCHARGE_ENABLE(dis_en),
        .REFERENCE_CODE(ref_code), .OUTPUT_IN_REGULATION_OUT(pg_out), .OUTPUT_IN_REGULATION_OE(pg_oe)
    );
    i2c_host_model u_i2c_host_model (.clk(clk), .scl(scl), .sda_low(sda_low),
        .sda_wire(sda_wire));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask
    task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
        u_i2c_host_model.start();
        u_i2c_host_model.write_byte(8'hd0, ack);
        check(16'(ack), 16'h0000);
        u_i2c_host_model.write_byte(ofs, ack);
        u_i2c_host_model.write_byte(d, ack);
        check(16'(ack), 16'h0000);
        u_i2c_host_model.stop();
    endtask
    task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
        u_i2c_host_model.start();
        u_i2c_host_model.write_byte(8'hd0, ack);
        u_i2c_host_model.write_byte(ofs, ack);
        u_i2c_host_model.start();
        u_i2c_host_model.write_byte(8'hd1, ack);
        check(16'(ack), 16'h0000);
        u_i2c_host_model.read_byte(1'b1, d);
        u_i2c_host_model.stop();
    endtask
    task automatic pg_case(input logic a, input logic b, input logic exp);
        vout_above = a;
        vout_below = b;
        settle();
        check(16'(pg_oe), 16'(exp));
    endtask
    task automatic wait_ref(input logic [6:0] t);
        int i;
        i = 0;
        while (ref_code !== t && i < 5000) begin
            @(negedge clk);
            i++;
        end
        check(16'(ref_code), 16'(t));
    endtask
    // cycles between the first and second step away from a start code
    task automatic ramp_step(input logic [6:0] s, output int cnt);
        logic [6:0] first;
        cnt = 0;
        while (ref_code === s && cnt < 5000) begin
            @(negedge clk);
            cnt++;
        end
        first = ref_code;
        cnt = 0;
        while (ref_code === first && cnt < 5000) begin
            @(negedge clk);
            cnt++;
        end
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        en_pin = 1'b1;
        vin_above = 1'b0;
        vin_below = 1'b1;
        vout_above = 1'b0;
        vout_below = 1'b0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        settle();
        check(16'(conv_on), 16'h0001);
        check(16'(fcm), 16'h0001);
        check(16'(fsw), 16'h0002);
        check(16'(dis_en), 16'h0000);
        check(16'(ref_code), 16'h004e);
        check(16'({sda_out, pg_out}), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            reg_read(8'(k), rd);
            check(16'(rd), 16'(rst_tab[k]));
        end
        // foreign address is not acknowledged
        u_i2c_host_model.start();
        u_i2c_host_model.write_byte(8'hd2, ack);
        check(16'(ack), 16'h0001);
        u_i2c_host_model.stop();
        // enable pin and software enable
        en_pin = 1'b0;
        settle();
        check(16'(conv_on), 16'h0000);
        en_pin = 1'b1;
        reg_write(8'h00, 8'h4e);
        settle();
        check(16'(conv_on), 16'h0000);
        reg_write(8'h02, 8'h00);
        reg_write(8'h00, 8'hcc);
        settle();
        check(16'(conv_on), 16'h0001);
        repeat (60) @(negedge clk);
        check(16'(ref_code), 16'h004e);
        // input over-voltage with hysteresis, then disabled
        vin_below = 1'b0;
        vin_above = 1'b1;
        settle();
        check(16'(conv_on), 16'h0000);
        vin_above = 1'b0;
        settle();
        check(16'(conv_on), 16'h0000);
        vin_below = 1'b1;
        settle();
        check(16'(conv_on), 16'h0001);
        reg_write(8'h01, 8'h45);
        vin_below = 1'b0;
        vin_above = 1'b1;
        settle();
        check(16'(conv_on), 16'h0001);
        vin_above = 1'b0;
        vin_below = 1'b1;
        // power-good both sides, then low side only
        pg_case(1'b0, 1'b0, 1'b0);
        pg_case(1'b1, 1'b0, 1'b1);
        pg_case(1'b0, 1'b1, 1'b1);
        for (int k = 0; k < 8; k++) begin
            reg_write(8'h01, {3'(k), 5'h07});
            check(16'(fsw), 16'(k));
        end
        reg_write(8'h01, 8'h40);
        settle();
        check(16'(fcm), 16'h0000);
        pg_case(1'b1, 1'b0, 1'b0);
        pg_case(1'b0, 1'b1, 1'b1);
        pg_case(1'b0, 1'b0, 1'b0);
        reg_read(8'h01, rd);
        check(16'(rd), 16'h0040);
        // permit, then ramp period for every slew code, even codes up, odd codes down
        cur = 7'h4c;
        for (int k = 0; k < 8; k++) begin
            reg_write(8'h02, 8'h20 | 8'(k));
            wait_ref(cur);
            tgt = (k % 2 == 1) ? cur - 7'h02 : cur + 7'h02;
            fork
                reg_write(8'h00, {1'b1, tgt});
                ramp_step(cur, n);
            join
            check(16'(n), 16'(15 << k));
            wait_ref(tgt);
            cur = tgt;
        end
        // discharge, reserved bit reads zero
        reg_write(8'h02, 8'h18);
        settle();
        check(16'(dis_en), 16'h0001);
        reg_read(8'h02, rd);
        check(16'(rd), 16'h0010);
        wrap_up();
    end
endmodule
